// >>> shared/hsp_cfg.svh
// Constants for the host serial register port
`ifndef HSP_CFG_SVH
`define HSP_CFG_SVH
// ============================================================
// Clock and reference
`define HSP_CLK_NS      10
`define HSP_CLK_KHZ     100000
`define HSP_REF_KHZ     27120
// Phase step per clock that yields the 27.12 MHz reference tick
`define HSP_REF_STEP    14'(`HSP_REF_KHZ / 10)
`define HSP_REF_MOD     14'(`HSP_CLK_KHZ / 10)
// ============================================================
// SPI timing: 10 Mbit/s gives a 50 ns least half period
`define HSP_SPI_MBPS    10
`define HSP_SPI_HALF_NS (1000 / (2 * `HSP_SPI_MBPS))
`define HSP_SPI_HALF_CYC ((`HSP_SPI_HALF_NS + `HSP_CLK_NS - 1) / `HSP_CLK_NS)
// ============================================================
// UART rate register
`define HSP_RATE_ADDR   6'h1F
`define HSP_RATE_RST    8'hEB
`define HSP_EXP_MSB     7
`define HSP_EXP_LSB     5
`define HSP_MAN_MSB     4
`define HSP_MAN_OFS     13'h21
// ============================================================
// Write buffer
`define HSP_FIFO_DEPTH  8
`define HSP_WR_W        14
`endif

// >>> shared/hsp_pkg.sv
// Types for the host serial register port
package hsp_pkg;
  typedef enum logic [1:0] {
    M_NONE = 2'h0,
    M_UART = 2'h1,
    M_SPI  = 2'h2,
    M_I2C  = 2'h3
  } hsp_mode_t;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h2,
    RX_STOP  = 2'h3
  } hsp_rx_t;
  typedef struct packed {
    hsp_mode_t   mode;
    logic [1:0]  strap_cnt;
    logic [2:0]  sck_sy, nss_sy, mosi_sy, rx_sy, scl_sy, sda_sy, i2c_sy, ea_sy;
    logic        sck_lvl, scl_lvl, sda_lvl;
    logic [13:0] ref_acc;
    logic [7:0]  rate;
    logic [2:0]  spi_bit;
    logic        spi_first, spi_rd, spi_load;
    logic [5:0]  spi_addr;
    logic [7:0]  spi_rx, spi_tx;
    hsp_rx_t     rx_st;
    logic [12:0] rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        u_wait, u_load;
    logic [5:0]  u_addr;
    logic        tx_busy, tx_pend;
    logic [9:0]  tx_sh;
    logic [3:0]  tx_bit;
    logic [12:0] tx_cnt;
    logic [7:0]  tx_byte;
    logic [5:0]  rd_addr;
    logic        rd_stb, wr_pend;
    logic [5:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        txo, dreq, aux, sda_oe;
  } hsp_st_t;
endpackage

// >>> core/hsp_port.sv
// Host serial register port: SPI, UART and I2C slave front ends
`timescale 1ns/10ps
`include "hsp_cfg.svh"

// ============================================================
// Write buffer
module hsp_fifo #(
  parameter int W = `HSP_WR_W,
  parameter int D = `HSP_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } hsp_fifo_st_t;
  hsp_fifo_st_t s, n;
  logic push, pop;

  assign in_ready  = (s.cnt != (AW+1)'(D));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];

  always_comb begin
    n = s;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      n.mem[s.wp] = in_data;
      n.wp = (s.wp == AW'(D-1)) ? '0 : s.wp + AW'(1);
    end
    if (pop) begin
      n.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + AW'(1);
    end
    n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

// ============================================================
// Port top
module hsp_port
  import hsp_pkg::*;
#(
  parameter int FIFO_DEPTH = `HSP_FIFO_DEPTH
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       SEL_I2C,
  input  wire logic       SEL_EA,
  input  wire logic       SPI_SCK,
  input  wire logic       SPI_NSS,
  input  wire logic       SPI_MOSI,
  output logic            SPI_MISO,
  input  wire logic       UART_RX,
  output logic            UART_TX,
  output logic            UART_DREQ,
  output logic            UART_AUX,
  input  wire logic       LINE_SIG_EN,
  input  wire logic       I2C_SCL,
  input  wire logic       I2C_SDA_I,
  output logic            I2C_SDA_O,
  output logic            I2C_SDA_OE,
  input  wire logic       I2C_PULL,
  output logic            I2C_SCL_LVL,
  output logic            I2C_SDA_LVL,
  output logic [1:0]      MODE,
  output logic [7:0]      RATE,
  output logic [5:0]      RD_ADDR,
  output logic            RD_STB,
  input  wire logic [7:0] RD_DATA,
  output logic            WR_VALID,
  input  wire logic       WR_READY,
  output logic [5:0]      WR_ADDR,
  output logic [7:0]      WR_DATA
);
  hsp_st_t     s, n;
  logic [13:0] acc_sum;
  logic        tick, sck_rise, sck_fall, nss_hi, spi_done, push, in_ready, u_done;
  logic [12:0] div;
  logic [7:0]  b_spi;

  // Divisor in reference ticks
  function automatic logic [12:0] div_of(input logic [7:0] r);
    logic [2:0] e;
    e = r[`HSP_EXP_MSB:`HSP_EXP_LSB];
    if (e == 3'h0) return 13'(r[`HSP_MAN_MSB:0]) + 13'h1;
    return (13'(r[`HSP_MAN_MSB:0]) + `HSP_MAN_OFS) << (e - 3'h1);
  endfunction

  hsp_fifo #(.W(`HSP_WR_W), .D(FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (s.wr_pend),
    .in_ready  (in_ready),
    .in_data   ({s.wr_addr, s.wr_data}),
    .out_valid (WR_VALID),
    .out_ready (WR_READY),
    .out_data  ({WR_ADDR, WR_DATA})
  );

  assign SPI_MISO    = s.spi_tx[7];
  assign UART_TX     = s.txo;
  assign UART_DREQ   = s.dreq;
  assign UART_AUX    = s.aux;
  assign I2C_SDA_O   = 1'b0;
  assign I2C_SDA_OE  = s.sda_oe;
  assign I2C_SCL_LVL = s.scl_lvl;
  assign I2C_SDA_LVL = s.sda_lvl;
  assign MODE        = s.mode;
  assign RATE        = s.rate;
  assign RD_ADDR     = s.rd_addr;
  assign RD_STB      = s.rd_stb;

  always_comb begin
    n        = s;
    acc_sum  = s.ref_acc + `HSP_REF_STEP;
    tick     = (acc_sum >= `HSP_REF_MOD);
    div      = div_of(s.rate);
    // A change counts once second and third stage agree
    sck_rise = (s.sck_sy[2:1] == 2'h3) && !s.sck_lvl;
    sck_fall = (s.sck_sy[2:1] == 2'h0) && s.sck_lvl;
    nss_hi   = (s.nss_sy[2:1] == 2'h3);
    b_spi    = {s.spi_rx[6:0], s.mosi_sy[2]};
    spi_done = (s.mode == M_SPI) && !nss_hi && sck_rise && (s.spi_bit == 3'h7);
    push     = s.wr_pend && in_ready;
    u_done   = (s.rx_st == RX_STOP) && tick && (s.rx_cnt == 13'h0)
               && (s.rx_sy[2:1] == 2'h3);

    // Three-stage synchronisers
    n.sck_sy  = {s.sck_sy[1:0], SPI_SCK};
    n.nss_sy  = {s.nss_sy[1:0], SPI_NSS};
    n.mosi_sy = {s.mosi_sy[1:0], SPI_MOSI};
    n.rx_sy   = {s.rx_sy[1:0], UART_RX};
    n.scl_sy  = {s.scl_sy[1:0], I2C_SCL};
    n.sda_sy  = {s.sda_sy[1:0], I2C_SDA_I};
    n.i2c_sy  = {s.i2c_sy[1:0], SEL_I2C};
    n.ea_sy   = {s.ea_sy[1:0], SEL_EA};
    if (s.sck_sy[2] == s.sck_sy[1]) n.sck_lvl = s.sck_sy[2];
    if (s.scl_sy[2] == s.scl_sy[1]) n.scl_lvl = s.scl_sy[2];
    if (s.sda_sy[2] == s.sda_sy[1]) n.sda_lvl = s.sda_sy[2];

    // Straps are read once after reset; the mode then holds until reset
    if (s.mode == M_NONE) begin
      if (s.strap_cnt != 2'h3) begin
        n.strap_cnt = s.strap_cnt + 2'h1;
      end else if (s.i2c_sy[2] == s.i2c_sy[1] && s.ea_sy[2] == s.ea_sy[1]) begin
        n.mode = s.i2c_sy[2] ? M_I2C : (s.ea_sy[2] ? M_SPI : M_UART);
      end
    end

    n.ref_acc  = tick ? acc_sum - `HSP_REF_MOD : acc_sum;
    n.rd_stb   = 1'b0;
    n.spi_load = 1'b0;
    n.u_load   = 1'b0;

    // Write path: the pending write stalls until the buffer takes it
    if (push) begin
      n.wr_pend = 1'b0;
      if (s.wr_addr == `HSP_RATE_ADDR) n.rate = s.wr_data;
    end

    // ==========================================================
    // SPI slave; the host owns the clock, we only follow it
    if (s.mode == M_SPI) begin
      if (nss_hi) begin
        n.spi_bit   = 3'h0;
        n.spi_first = 1'b1;
        n.spi_tx    = 8'h0;
      end else begin
        if (sck_rise) begin
          n.spi_rx  = b_spi;
          n.spi_bit = s.spi_bit + 3'h1;
        end
        if (sck_fall && s.spi_bit != 3'h0) begin
          n.spi_tx = {s.spi_tx[6:0], 1'b0};
        end
        if (spi_done) begin
          n.spi_first = 1'b0;
          if (s.spi_first) begin
            n.spi_rd   = b_spi[7];
            n.spi_addr = b_spi[6:1];
            n.spi_tx   = 8'h0;
          end
          if (s.spi_first ? b_spi[7] : s.spi_rd) begin
            n.rd_stb  = 1'b1;
            n.rd_addr = b_spi[6:1];
            n.spi_load = 1'b1;
          end else if (!s.spi_first) begin
            n.wr_pend = 1'b1;
            n.wr_addr = s.spi_addr;
            n.wr_data = b_spi;
          end
        end
      end
      if (s.spi_load) n.spi_tx = RD_DATA;
    end

    // ==========================================================
    // UART receiver, runs on reference ticks
    if (s.mode == M_UART && tick) begin
      if (s.rx_cnt != 13'h0) begin
        n.rx_cnt = s.rx_cnt - 13'h1;
      end else begin
        unique case (s.rx_st)
          RX_IDLE: begin
            if (s.rx_sy[2:1] == 2'h0) begin
              n.rx_st  = RX_START;
              n.rx_cnt = div >> 1;
            end
          end
          RX_START: begin
            n.rx_st  = (s.rx_sy[2:1] == 2'h0) ? RX_DATA : RX_IDLE;
            // A false start must leave the receiver ready at once, not blind for a bit
            n.rx_cnt = (s.rx_sy[2:1] == 2'h0) ? div - 13'h1 : 13'h0;
            n.rx_bit = 3'h0;
          end
          RX_DATA: begin
            n.rx_sh  = {s.rx_sy[2], s.rx_sh[7:1]};
            n.rx_bit = s.rx_bit + 3'h1;
            n.rx_cnt = div - 13'h1;
            if (s.rx_bit == 3'h7) n.rx_st = RX_STOP;
          end
          RX_STOP: begin
            n.rx_st = RX_IDLE;
          end
        endcase
      end
    end

    // Byte handling is independent of the echo still in flight
    if (u_done) begin
      if (s.u_wait) begin
        n.u_wait  = 1'b0;
        n.wr_pend = 1'b1;
        n.wr_addr = s.u_addr;
        n.wr_data = s.rx_sh;
      end else if (s.rx_sh[7]) begin
        n.rd_stb  = 1'b1;
        n.rd_addr = s.rx_sh[5:0];
        n.u_load  = 1'b1;
      end else begin
        n.u_wait  = 1'b1;
        n.u_addr  = s.rx_sh[5:0];
        n.tx_pend = 1'b1;
        n.tx_byte = s.rx_sh;
      end
    end
    if (s.u_load) begin
      n.tx_pend = 1'b1;
      n.tx_byte = RD_DATA;
    end

    // ==========================================================
    // UART transmitter; one byte may wait behind the one on the line
    if (s.mode == M_UART && !s.tx_busy && s.tx_pend) begin
      n.tx_busy = 1'b1;
      // A byte queued in this same cycle must not be dropped
      n.tx_pend = s.u_load || (u_done && !s.u_wait && !s.rx_sh[7]);
      n.tx_sh   = {1'b1, s.tx_byte, 1'b0};
      n.tx_bit  = 4'h0;
      n.tx_cnt  = div - 13'h1;
    end else if (s.tx_busy && tick) begin
      if (s.tx_cnt != 13'h0) begin
        n.tx_cnt = s.tx_cnt - 13'h1;
      end else if (s.tx_bit == 4'h9) begin
        n.tx_busy = 1'b0;
      end else begin
        n.tx_sh  = {1'b1, s.tx_sh[9:1]};
        n.tx_bit = s.tx_bit + 4'h1;
        n.tx_cnt = div - 13'h1;
      end
    end
    n.txo = n.tx_busy ? n.tx_sh[0] : 1'b1;

    // Line signals: request shows a byte headed to the host, aux a stall
    n.dreq   = (s.mode == M_UART) && LINE_SIG_EN && (s.tx_busy || s.tx_pend);
    n.aux    = (s.mode == M_UART) && LINE_SIG_EN && !in_ready;
    // Open-drain: only a low is ever driven, the bus idles high
    n.sda_oe = (s.mode == M_I2C) && I2C_PULL;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s      <= '0;
      s.rate <= `HSP_RATE_RST;
      s.txo  <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_spi_shift_out: assert property (
    (s.mode == M_SPI && sck_fall && !nss_hi && s.spi_bit != 3'h0 && !s.spi_load)
    |=> (s.spi_tx == ($past(s.spi_tx) << 1)))
    else $error("MISO did not advance on falling edge");
  a_spi_read_load: assert property (
    (spi_done && (s.spi_first ? b_spi[7] : s.spi_rd))
    |=> RD_STB ##1 (s.spi_tx == $past(RD_DATA)))
    else $error("SPI read data not loaded");
  a_spi_write_quiet: assert property (
    (s.mode == M_SPI && !s.spi_first && !s.spi_rd) |-> !SPI_MISO)
    else $error("MISO active in write burst");
  a_spi_frame_end: assert property (
    (s.mode == M_SPI && nss_hi) |=> (s.spi_first && s.spi_bit == 3'h0))
    else $error("Burst not reset by select");
  a_rate_hold: assert property (
    !(push && s.wr_addr == `HSP_RATE_ADDR) |=> $stable(s.rate))
    else $error("Rate changed without write");
  a_rate_write: assert property (
    (push && s.wr_addr == `HSP_RATE_ADDR) |=> (RATE == $past(s.wr_data)))
    else $error("Rate write lost");
  a_uart_echo: assert property (
    (u_done && !s.u_wait && !s.rx_sh[7]) |=> (s.tx_pend && s.tx_byte == $past(s.rx_sh)))
    else $error("Write address not echoed");
  a_tx_start_bit: assert property (
    (s.mode == M_UART && !s.tx_busy && s.tx_pend) |=> (!UART_TX ##1 !UART_TX))
    else $error("Start bit missing");
  a_line_gate: assert property (
    !LINE_SIG_EN |=> (!UART_DREQ && !UART_AUX))
    else $error("Line signals active while disabled");
  a_sda_pull_only: assert property (
    I2C_SDA_OE |-> (s.mode == M_I2C && !I2C_SDA_O))
    else $error("SDA driven outside pull-low");
endmodule

// >>> sim/hsp_host.sv
// Host model: SPI master facing the port's slave side
`timescale 1ns/10ps
module hsp_host #(
  parameter int HALF = 8
) (
  input  wire logic clk,
  output logic      sck,
  output logic      nss,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck = 1'b0;
    nss = 1'b1;
    mosi = 1'b1;
  end

  // ============================================================
  // Idle data line
  // A deselected line toggles so a stale bit can never pass for data
  always @(posedge clk) begin
    if (nss) begin
      mosi <= ~mosi;
    end
  end

  // ============================================================
  // Framing
  task automatic select(input logic v);
    @(posedge clk);
    nss <= v;
    repeat (HALF) @(posedge clk);
  endtask

  // ============================================================
  // One byte; half period of 8 cycles keeps margin over the 5 cycle minimum
  task automatic spi_byte(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi <= d[i];
      repeat (HALF) @(posedge clk);
      sck <= 1'b1;
      r[i] = miso;
      repeat (HALF) @(posedge clk);
      sck <= 1'b0;
    end
  endtask
endmodule

// >>> sim/test_hsp_port.sv
// Self-checking testbench for the host serial register port
`timescale 1ns/10ps
module test_hsp_port;
  import hsp_pkg::*;
  logic       clk, rst_n, sel_i2c, sel_ea, sck, nss, mosi, miso;
  logic       uart_tx, dreq, aux, line_en, scl, sda, sda_o, sda_oe, pull, urx;
  logic       scl_lvl, sda_lvl, rd_stb, wr_valid, wr_ready;
  logic [1:0] mode;
  logic [7:0] rate, rd_data, wr_data, rx;
  logic [5:0] rd_addr, wr_addr;
  logic [5:0] pop_a [$];
  logic [7:0] pop_d [$];
  logic [7:0] rd_ad [0:3];
  int         fails, n_tests, n_stb;

  // Open-drain data wire with pull-up
  assign sda = ~sda_oe;
  // Register file stand-in
  assign rd_data = {rd_addr[1:0], rd_addr};

  hsp_port i_hsp_port (
    .CLK(clk), .RST_N(rst_n), .SEL_I2C(sel_i2c), .SEL_EA(sel_ea),
    .SPI_SCK(sck), .SPI_NSS(nss), .SPI_MOSI(mosi), .SPI_MISO(miso),
    .UART_RX(urx), .UART_TX(uart_tx), .UART_DREQ(dreq), .UART_AUX(aux),
    .LINE_SIG_EN(line_en), .I2C_SCL(scl), .I2C_SDA_I(sda), .I2C_SDA_O(sda_o),
    .I2C_SDA_OE(sda_oe), .I2C_PULL(pull), .I2C_SCL_LVL(scl_lvl),
    .I2C_SDA_LVL(sda_lvl), .MODE(mode), .RATE(rate), .RD_ADDR(rd_addr),
    .RD_STB(rd_stb), .RD_DATA(rd_data), .WR_VALID(wr_valid),
    .WR_READY(wr_ready), .WR_ADDR(wr_addr), .WR_DATA(wr_data)
  );

  hsp_host i_hsp_host (
    .clk(clk), .sck(sck), .nss(nss), .mosi(mosi), .miso(miso)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rd_stb) begin
      n_stb++;
    end
    if (wr_valid && wr_ready) begin
      pop_a.push_back(wr_addr);
      pop_d.push_back(wr_data);
    end
  end

  // ============================================================
  // Helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Straps must stay steady well past release
  task automatic rst(input logic i2c, input logic ea);
    @(posedge clk);
    rst_n <= 1'b0;
    sel_i2c <= i2c;
    sel_ea <= ea;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic wait_pops(input int n);
    int k;
    for (k = 0; k < 400 && pop_a.size() < n; k++) @(posedge clk);
    if (pop_a.size() < n) begin
      $display("[FAIL] write drain expected %0d seen %0d", n, pop_a.size());
      fails++;
      summarize();
    end
    repeat (4) @(posedge clk);
  endtask

  // ============================================================
  // Tests
  initial begin
    rst_n = 1'b0;
    sel_i2c = 1'b0;
    sel_ea = 1'b1;
    line_en = 1'b1;
    scl = 1'b1;
    pull = 1'b0;
    wr_ready = 1'b0;
    urx = 1'b1;
    fails = 0;
    n_tests = 0;
    n_stb = 0;
    rd_ad = '{8'h8A, 8'hD4, 8'hFE, 8'h00};

    rst(1'b0, 1'b1);
    chk("mode spi", 8'h02, {6'h00, mode});
    chk("rate reset", 8'hEB, rate);
    // Read burst: each byte returns the previous address's data
    i_hsp_host.select(1'b0);
    for (int b = 0; b < 4; b++) begin
      i_hsp_host.spi_byte(rd_ad[b], rx);
      if (b > 0) chk("read data", {rd_ad[b-1][2:1], rd_ad[b-1][6:1]}, rx);
    end
    i_hsp_host.select(1'b1);
    chk("read strobes", 8'h04, 8'(n_stb));
    $display("test spi read done");

    // Write burst into a stalled buffer: 8 stored, one held pending
    i_hsp_host.select(1'b0);
    i_hsp_host.spi_byte(8'h22, rx);
    chk("write miso", 8'h00, rx);
    for (int b = 0; b < 9; b++) begin
      i_hsp_host.spi_byte(8'hC0 + 8'(b), rx);
      chk("write miso", 8'h00, rx);
    end
    i_hsp_host.select(1'b1);
    chk("valid held", 8'h01, {7'h00, wr_valid});
    chk("aux off in spi", 8'h00, {7'h00, aux});
    @(posedge clk);
    wr_ready <= 1'b1;
    wait_pops(9);
    for (int b = 0; b < 9; b++) begin
      chk("write addr", 8'h11, {2'h0, pop_a[b]});
      chk("write data", 8'hC0 + 8'(b), pop_d[b]);
    end
    $display("test spi write done");

    // New frame starts with an address byte again
    i_hsp_host.select(1'b0);
    i_hsp_host.spi_byte(8'h3E, rx);
    i_hsp_host.spi_byte(8'h15, rx);
    i_hsp_host.select(1'b1);
    wait_pops(10);
    chk("rate write", 8'h15, rate);
    chk("reframe addr", 8'h1F, {2'h0, pop_a[9]});
    chk("reframe data", 8'h15, pop_d[9]);
    $display("test spi reframe done");

    line_en <= 1'b0;
    rst(1'b0, 1'b0);
    chk("mode uart", 8'h01, {6'h00, mode});
    chk("uart rate", 8'hEB, rate);
    chk("tx idle", 8'h01, {7'h00, uart_tx});
    chk("dreq off", 8'h00, {7'h00, dreq});
    chk("aux off", 8'h00, {7'h00, aux});
    // A low glitch far shorter than half a bit is a false start, not a character
    urx <= 1'b0;
    repeat (40) @(posedge clk);
    urx <= 1'b1;
    repeat (2000) @(posedge clk);
    chk("rx start seen", {6'h00, RX_START}, {6'h00, i_hsp_port.s.rx_st});
    repeat (6000) @(posedge clk);
    chk("rx back idle", {6'h00, RX_IDLE}, {6'h00, i_hsp_port.s.rx_st});
    chk("no uart read", 8'h04, 8'(n_stb));
    chk("tx after glitch", 8'h01, {7'h00, uart_tx});
    $display("test uart idle done");

    rst(1'b1, 1'b0);
    chk("mode i2c", 8'h03, {6'h00, mode});
    pull <= 1'b1;
    scl <= 1'b0;
    repeat (6) @(posedge clk);
    chk("sda pulled", 8'h01, {7'h00, sda_oe});
    chk("sda low", 8'h00, {7'h00, sda_o});
    chk("scl level", 8'h00, {7'h00, scl_lvl});
    chk("sda level", 8'h00, {7'h00, sda_lvl});
    pull <= 1'b0;
    repeat (6) @(posedge clk);
    chk("sda released", 8'h00, {7'h00, sda_oe});
    chk("sda idle", 8'h01, {7'h00, sda_lvl});
    $display("test i2c front done");
    summarize();
  end
endmodule
